/* sim/aid_job_ctrl_properties.sv */
// port assertions for the diagnostic job handler
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module aid_job_ctrl_properties #(
   parameter int LOCK_CYCLES = 20
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic STAT_REQ,
   input wire logic [4:0] STAT_SLAVE,
   input wire logic STAT_CLEAR,
   input wire logic STAT_ACK,
   input wire logic [3:0] STAT_VALUE,
   input wire logic ADDR_LOCK
);
   // ==========================================================
   // helpers
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   wire logic job_stat = PSEL && PENABLE && PWRITE &&
      PADDR == aid_pkg::OFF_JOB && PWDATA[7:0] == aid_pkg::JOB_STATUS;
   wire logic [4:0] wr_slave = PWDATA[12:8];
   wire logic vol_ans = STAT_REQ && STAT_ACK && STAT_VALUE[0];
   int cnt_d;
   int cnt_q;
   // restarts on a fresh volatile answer, since the lock retriggers
   always_comb cnt_d = (!ADDR_LOCK || vol_ans) ? 0 : cnt_q + 1;
   always_ff @(posedge CLK) cnt_q <= RST ? 0 : cnt_d;

   // ==========================================================
   // assertions
   AST_ZERO_WAIT: assert property (PREADY)
      else $error("wait state seen");
   AST_CLEAR_WITH_READ: assert property (STAT_REQ |-> STAT_CLEAR)
      else $error("status read without clear");
   AST_REQ_HELD: assert property (STAT_REQ && !STAT_ACK |=>
      STAT_REQ && $stable(STAT_SLAVE))
      else $error("status request dropped early");
   AST_REQ_DONE: assert property (STAT_REQ && STAT_ACK |=> !STAT_REQ)
      else $error("status request held after answer");
   AST_REQ_CAUSE: assert property ($rose(STAT_REQ) |->
      $past(job_stat) && STAT_SLAVE == $past(wr_slave))
      else $error("status request without job");
   AST_LOCK_START: assert property (vol_ans |=> ADDR_LOCK)
      else $error("lock missing after volatile flag");
   AST_LOCK_SPAN: assert property ($rose(ADDR_LOCK) |-> ADDR_LOCK[*8])
      else $error("lock too short");
   AST_LOCK_CAUSE: assert property (!ADDR_LOCK && !vol_ans |=>
      !ADDR_LOCK)
      else $error("lock without cause");
   AST_LOCK_END: assert property (ADDR_LOCK |-> cnt_q < LOCK_CYCLES)
      else $error("lock too long");
   AST_LOCK_FULL: assert property (ADDR_LOCK && !vol_ans &&
      cnt_q < LOCK_CYCLES - 1 |=> ADDR_LOCK)
      else $error("lock ended early");
endmodule : aid_job_ctrl_properties

bind aid_job_ctrl aid_job_ctrl_properties #(.LOCK_CYCLES(LOCK_CYCLES))
   u_props (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
   .STAT_REQ(STAT_REQ), .STAT_SLAVE(STAT_SLAVE), .STAT_CLEAR(STAT_CLEAR),
   .STAT_ACK(STAT_ACK), .STAT_VALUE(STAT_VALUE), .ADDR_LOCK(ADDR_LOCK));

/* sim/aid_job_ctrl_test.sv */
// self-checking bench for the diagnostic job handler
// assumes the cable model and the property checker are compiled first
`timescale 1ns/1ps
module aid_job_ctrl_test;
   // ==========================================================
   // signals and instances
   localparam int LOCK = 20;
   logic CLK, RST, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic echo_valid, stat_req, stat_clear, stat_ack, addr_lock;
   logic [4:0] echo_slave, stat_slave;
   logic [3:0] echo_value, stat_value;
   logic [3:0] echo_exp [0:31];
   logic [7:0] bytes [0:31];
   int mismatches = 0;
   int samples_checked = 0;

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   aid_job_ctrl #(.LOCK_CYCLES(LOCK), .VER_MAJOR(4'h2),
      .VER_MINOR_TENS(4'h4), .VER_MINOR_ONES(4'h7)) u_dut (
      .CLK(CLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
      .ECHO_VALID(echo_valid), .ECHO_SLAVE(echo_slave),
      .ECHO_VALUE(echo_value), .STAT_REQ(stat_req),
      .STAT_SLAVE(stat_slave), .STAT_CLEAR(stat_clear),
      .STAT_ACK(stat_ack), .STAT_VALUE(stat_value),
      .ADDR_LOCK(addr_lock));

   aid_slave_link u_link (.clk(CLK), .stat_req(stat_req),
      .stat_slave(stat_slave), .stat_clear(stat_clear),
      .stat_ack(stat_ack), .stat_value(stat_value),
      .echo_valid(echo_valid), .echo_slave(echo_slave),
      .echo_value(echo_value));

   // ==========================================================
   // shared tasks
   task automatic wrap_up();
      $display("mismatches %0d samples_checked %0d", mismatches,
         samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // one idle cycle after each transfer keeps psel edges clean
   task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge CLK);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge CLK);
   endtask : apb

   task automatic run_job(input logic [31:0] job);
      int n;
      apb(aid_pkg::OFF_JOB, 1'b1, job);
      n = 0;
      do begin
         apb(aid_pkg::OFF_STATUS, 1'b0, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      if (n >= 100) begin
         mismatches++;
         wrap_up();
      end
   endtask : run_job

   task automatic read_buf();
      for (int w = 0; w < 8; w++) begin
         apb(aid_pkg::OFF_RX_BUF + 8'(4 * w), 1'b0, 32'h0);
         for (int k = 0; k < 4; k++) bytes[4 * w + k] = rd[8 * k +: 8];
      end
   endtask : read_buf

   // ==========================================================
   // scenarios
   task automatic sc_echo();
      for (int s = 0; s < 32; s++) begin
         echo_exp[s] = 4'(s) ^ 4'hA;
         u_link.send_echo(5'(s), echo_exp[s]);
      end
      echo_exp[5] = 4'h3;
      u_link.send_echo(5'h05, 4'h3);
      apb(aid_pkg::OFF_IRQ_MASK, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(aid_pkg::OFF_IRQ_MASK, 1'b1, 32'h7);
      run_job({24'h0, aid_pkg::JOB_ECHO_LIST});
      chk(32'(irq), 32'h1);
      apb(aid_pkg::OFF_RX_LEN, 1'b0, 32'h0);
      chk(rd, 32'h10);
      read_buf();
      chk({24'h0, bytes[0]}, {28'h0, echo_exp[1]});
      for (int n = 1; n < 16; n++) begin
         rd = {24'h0, echo_exp[2*n], echo_exp[2*n+1]};
         chk({24'h0, bytes[n]}, rd);
      end
      apb(aid_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
      chk(rd, 32'h1);
      chk(32'(irq), 32'h0);
   endtask : sc_echo

   task automatic sc_version();
      logic [7:0] v [0:29];
      for (int k = 0; k < 26; k++) v[k] = aid_pkg::VER_NAME[8*(25-k) +: 8];
      v[26] = 8'h32;
      v[27] = 8'h2E;
      v[28] = 8'h34;
      v[29] = 8'h37;
      apb(aid_pkg::OFF_JOB, 1'b1, {24'h0, aid_pkg::JOB_VERSION});
      // a status job written while the fill runs must be dropped
      run_job(32'h0716);
      apb(aid_pkg::OFF_JOB, 1'b0, 32'h0);
      chk(rd, 32'h14);
      apb(aid_pkg::OFF_RX_LEN, 1'b0, 32'h0);
      chk(rd, 32'h1E);
      read_buf();
      for (int k = 0; k < 30; k++) begin
         chk({24'h0, bytes[k]}, {24'h0, v[k]});
      end
   endtask : sc_version

   task automatic sc_status();
      u_link.wait_cyc = 5;
      u_link.set_flags(5'h07, 4'hE);
      run_job(32'h0716);
      apb(aid_pkg::OFF_RX_LEN, 1'b0, 32'h0);
      chk(rd, 32'h1);
      apb(aid_pkg::OFF_RX_BUF, 1'b0, 32'h0);
      chk(rd & 32'hFF, 32'h0E);
      run_job(32'h0716);
      apb(aid_pkg::OFF_RX_BUF, 1'b0, 32'h0);
      chk(rd & 32'hFF, 32'h0);
      u_link.wait_cyc = 0;
      for (int b = 3; b >= 0; b--) begin
         u_link.set_flags(5'h09, 4'(1 << b));
         apb(aid_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
         run_job(32'h0916);
         apb(aid_pkg::OFF_RX_BUF, 1'b0, 32'h0);
         chk(rd & 32'hFF, 32'(1 << b));
      end
      chk(32'(addr_lock), 32'h1);
      apb(aid_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
      chk(rd, 32'h5);
      apb(aid_pkg::OFF_STATUS, 1'b0, 32'h0);
      chk(rd, 32'h2);
      repeat (LOCK + 5) @(posedge CLK);
      chk(32'(addr_lock), 32'h0);
   endtask : sc_status

   task automatic sc_bad();
      apb(8'h20, 1'b0, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      run_job(32'h15);
      chk(32'(irq), 32'h1);
      apb(aid_pkg::OFF_IRQ_MASK, 1'b1, 32'h0);
      chk(32'(irq), 32'h0);
      apb(aid_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
      chk(rd, 32'h2);
      apb(aid_pkg::OFF_RX_LEN, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(aid_pkg::OFF_JOB, 1'b0, 32'h0);
      chk(rd, 32'h15);
   endtask : sc_bad

   initial begin
      RST = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      sc_echo();
      sc_version();
      sc_status();
      sc_bad();
      wrap_up();
   end
endmodule : aid_job_ctrl_test

/* sim/aid_slave_link.sv */
// cable-side model: slave status flags and parameter echoes
// assumes the handler holds a status request until it is answered
`timescale 1ns/1ps
module aid_slave_link (
   input wire logic clk,
   input wire logic stat_req,
   input wire logic [4:0] stat_slave,
   input wire logic stat_clear,
   output logic stat_ack,
   output logic [3:0] stat_value,
   output logic echo_valid,
   output logic [4:0] echo_slave,
   output logic [3:0] echo_value
);
   // ==========================================================
   // slave state
   logic [3:0] flags_q [0:31];
   int wait_cyc = 0;
   int cnt = 0;

   initial begin
      stat_ack = 1'b0;
      stat_value = 4'h0;
      echo_valid = 1'b0;
      echo_slave = 5'h00;
      echo_value = 4'h0;
      foreach (flags_q[i]) flags_q[i] = 4'h0;
   end

   // flags stay latched until a read-and-clear reaches the slave
   task automatic set_flags(input logic [4:0] s, input logic [3:0] v);
      flags_q[s] <= flags_q[s] | v;
   endtask : set_flags

   // idle lines show garbage, never the last value
   task automatic send_echo(input logic [4:0] s, input logic [3:0] v);
      echo_valid <= 1'b1;
      echo_slave <= s;
      echo_value <= v;
      @(posedge clk);
      echo_valid <= 1'b0;
      echo_slave <= ~s;
      echo_value <= ~v;
      @(posedge clk);
   endtask : send_echo

   always @(posedge clk) begin
      stat_ack <= 1'b0;
      stat_value <= ~stat_value;
      if (stat_req && !stat_ack) begin
         if (cnt >= wait_cyc) begin
            stat_ack <= 1'b1;
            stat_value <= flags_q[stat_slave];
            if (stat_clear)
               flags_q[stat_slave] <= 4'h0;
            cnt <= 0;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : aid_slave_link

/* src/aid_job_ctrl.sv */
// diagnostic job handler of a cable master: echo list, version, status
// assumes link logic on the same clock delivers echoes and status answers
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module aid_job_ctrl #(
   parameter int LOCK_CYCLES = aid_pkg::LOCK_CYC,
   parameter logic [3:0] VER_MAJOR = 4'h1,
   parameter logic [3:0] VER_MINOR_TENS = 4'h0,
   parameter logic [3:0] VER_MINOR_ONES = 4'h0
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   input wire logic ECHO_VALID,
   input wire logic [4:0] ECHO_SLAVE,
   input wire logic [3:0] ECHO_VALUE,
   output logic STAT_REQ,
   output logic [4:0] STAT_SLAVE,
   output logic STAT_CLEAR,
   input wire logic STAT_ACK,
   input wire logic [3:0] STAT_VALUE,
   output logic ADDR_LOCK
);

   // ==========================================================
   // helper functions

   // one byte of the echo list answer
   function automatic logic [7:0] echo_byte(
      input logic [3:0] echo [0:31],
      input logic [4:0] idx
   );
      logic [4:0] hi;
      logic [4:0] lo;
      hi = {idx[3:0], 1'b0};
      lo = {idx[3:0], 1'b1};
      // slave 0 does not exist, so byte 0 carries zero up top
      if (idx == 5'h00) begin
         echo_byte = {4'h0, echo[lo]};
      end else begin
         echo_byte = {echo[hi], echo[lo]};
      end
   endfunction : echo_byte

   // one character of the version string
   function automatic logic [7:0] ver_byte(input logic [4:0] idx);
      logic [4:0] rel;
      rel = idx - aid_pkg::VER_NUM_POS;
      ver_byte = aid_pkg::CHAR_ZERO;
      if (idx < aid_pkg::VER_NUM_POS) begin
         ver_byte = aid_pkg::VER_NAME[8*(aid_pkg::VER_NAME_LEN-1-32'(idx))
            +: 8];
      end else begin
         case (rel)
            5'h00: ver_byte = aid_pkg::CHAR_ZERO + {4'h0, VER_MAJOR};
            5'h01: ver_byte = aid_pkg::CHAR_DOT;
            5'h02: ver_byte = aid_pkg::CHAR_ZERO + {4'h0, VER_MINOR_TENS};
            5'h03: ver_byte = aid_pkg::CHAR_ZERO + {4'h0, VER_MINOR_ONES};
            default: ver_byte = aid_pkg::CHAR_ZERO;
         endcase
      end
   endfunction : ver_byte

   // ==========================================================
   // state
   aid_pkg::aid_state_type state_q;
   aid_pkg::aid_state_type state_d;
   logic [7:0] job_q;
   logic [7:0] job_d;
   logic [4:0] slave_q;
   logic [4:0] slave_d;
   logic [4:0] idx_q;
   logic [4:0] idx_d;
   logic [5:0] len_q;
   logic [5:0] len_d;
   logic [5:0] fill_len_q;
   logic [5:0] fill_len_d;
   logic [7:0] rx_q [0:aid_pkg::RX_BYTES-1];
   logic [7:0] rx_d [0:aid_pkg::RX_BYTES-1];
   logic [3:0] echo_q [0:31];
   logic [3:0] echo_d [0:31];
   logic [aid_pkg::IRQ_BITS-1:0] irq_stat_q;
   logic [aid_pkg::IRQ_BITS-1:0] irq_stat_d;
   logic [aid_pkg::IRQ_BITS-1:0] irq_mask_q;
   logic [aid_pkg::IRQ_BITS-1:0] irq_mask_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic stat_req_q;
   logic stat_req_d;
   logic lock_start;
   logic lock_busy;

   // ==========================================================
   // bus decode
   logic setup_ph;
   logic access_ph;
   logic wr_acc;
   logic rd_setup;
   logic mapped;
   logic in_rx_buf;
   logic [2:0] rx_word;

   assign setup_ph = PSEL & ~PENABLE;
   assign access_ph = PSEL & PENABLE;
   assign wr_acc = access_ph & PWRITE;
   assign rd_setup = setup_ph & ~PWRITE;
   assign in_rx_buf = (PADDR[7:5] == aid_pkg::OFF_RX_BUF[7:5])
      && (PADDR[1:0] == 2'b00);
   assign rx_word = PADDR[4:2];
   assign mapped = in_rx_buf
      || (PADDR == aid_pkg::OFF_JOB)
      || (PADDR == aid_pkg::OFF_STATUS)
      || (PADDR == aid_pkg::OFF_IRQ_STAT)
      || (PADDR == aid_pkg::OFF_IRQ_MASK)
      || (PADDR == aid_pkg::OFF_RX_LEN);

   // ==========================================================
   // job sequencing, buffers, interrupts and bus readback
   always_comb begin
      logic [aid_pkg::IRQ_BITS-1:0] ev;
      logic [7:0] wjob;
      ev = '0;
      wjob = PWDATA[7:0];
      state_d = state_q;
      job_d = job_q;
      slave_d = slave_q;
      idx_d = idx_q;
      len_d = len_q;
      fill_len_d = fill_len_q;
      rx_d = rx_q;
      echo_d = echo_q;
      irq_mask_d = irq_mask_q;
      prdata_d = prdata_q;
      stat_req_d = stat_req_q;
      lock_start = 1'b0;

      // latest echo per slave overwrites the old one
      if (ECHO_VALID && (ECHO_SLAVE != 5'h00)) begin
         echo_d[ECHO_SLAVE] = ECHO_VALUE;
      end

      case (state_q)
         aid_pkg::ST_IDLE: begin
            // a job written while busy is dropped by this state guard
            if (wr_acc && (PADDR == aid_pkg::OFF_JOB)) begin
               job_d = wjob;
               slave_d = PWDATA[12:8];
               idx_d = 5'h00;
               len_d = 6'h00;
               case (wjob)
                  aid_pkg::JOB_ECHO_LIST: begin
                     fill_len_d = aid_pkg::ECHO_LEN;
                     state_d = aid_pkg::ST_FILL;
                  end
                  aid_pkg::JOB_VERSION: begin
                     fill_len_d = aid_pkg::VER_LEN;
                     state_d = aid_pkg::ST_FILL;
                  end
                  aid_pkg::JOB_STATUS: begin
                     stat_req_d = 1'b1;
                     state_d = aid_pkg::ST_STAT;
                  end
                  default: begin
                     ev[aid_pkg::IRQ_BAD_JOB] = 1'b1;
                  end
               endcase
            end
         end
         aid_pkg::ST_FILL: begin
            if (job_q == aid_pkg::JOB_ECHO_LIST) begin
               rx_d[idx_q] = echo_byte(echo_q, idx_q);
            end else begin
               rx_d[idx_q] = ver_byte(idx_q);
            end
            idx_d = idx_q + 5'h01;
            if ({1'b0, idx_q} == fill_len_q - 6'h01) begin
               len_d = fill_len_q;
               ev[aid_pkg::IRQ_DONE] = 1'b1;
               state_d = aid_pkg::ST_IDLE;
            end
         end
         aid_pkg::ST_STAT: begin
            // request stands with read-and-clear set until the link acks
            if (STAT_ACK) begin
               rx_d[0] = {4'h0, STAT_VALUE};
               len_d = aid_pkg::STAT_LEN;
               stat_req_d = 1'b0;
               ev[aid_pkg::IRQ_DONE] = 1'b1;
               if (STAT_VALUE[aid_pkg::FLG_ADDR_VOLATILE]) begin
                  ev[aid_pkg::IRQ_VOLATILE] = 1'b1;
                  lock_start = 1'b1;
               end
               state_d = aid_pkg::ST_IDLE;
            end
         end
         default: begin
            stat_req_d = 1'b0;
            state_d = aid_pkg::ST_IDLE;
         end
      endcase

      if (wr_acc && (PADDR == aid_pkg::OFF_IRQ_MASK)) begin
         irq_mask_d = PWDATA[aid_pkg::IRQ_BITS-1:0];
      end

      // read clears only the bits latched at setup, so an event that lands
      // between setup and access is kept for the next read
      irq_stat_d = irq_stat_q;
      if (access_ph && !PWRITE && (PADDR == aid_pkg::OFF_IRQ_STAT)) begin
         irq_stat_d = irq_stat_q & ~prdata_q[aid_pkg::IRQ_BITS-1:0];
      end
      irq_stat_d = irq_stat_d | ev;

      // read data is latched in the setup phase, shown in the access phase
      if (rd_setup) begin
         prdata_d = 32'h0000_0000;
         if (in_rx_buf) begin
            prdata_d = {rx_q[{rx_word, 2'b11}], rx_q[{rx_word, 2'b10}],
               rx_q[{rx_word, 2'b01}], rx_q[{rx_word, 2'b00}]};
         end else begin
            case (PADDR)
               aid_pkg::OFF_JOB: begin
                  prdata_d = {19'h0_0000, slave_q, job_q};
               end
               aid_pkg::OFF_STATUS: begin
                  prdata_d[aid_pkg::STS_BUSY] =
                     (state_q != aid_pkg::ST_IDLE);
                  prdata_d[aid_pkg::STS_ADDR_LOCK] = lock_busy;
               end
               aid_pkg::OFF_IRQ_STAT: begin
                  prdata_d[aid_pkg::IRQ_BITS-1:0] = irq_stat_q;
               end
               aid_pkg::OFF_IRQ_MASK: begin
                  prdata_d[aid_pkg::IRQ_BITS-1:0] = irq_mask_q;
               end
               aid_pkg::OFF_RX_LEN: begin
                  prdata_d[5:0] = len_q;
               end
               default: begin
                  prdata_d = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_q <= aid_pkg::ST_IDLE;
         job_q <= 8'h00;
         slave_q <= 5'h00;
         idx_q <= 5'h00;
         len_q <= 6'h00;
         fill_len_q <= 6'h00;
         for (int i = 0; i < aid_pkg::RX_BYTES; i++) begin
            rx_q[i] <= 8'h00;
         end
         for (int i = 0; i < 32; i++) begin
            echo_q[i] <= 4'h0;
         end
         irq_stat_q <= aid_pkg::IRQ_RESET;
         irq_mask_q <= aid_pkg::IRQ_RESET;
         prdata_q <= 32'h0000_0000;
         stat_req_q <= 1'b0;
      end else begin
         state_q <= state_d;
         job_q <= job_d;
         slave_q <= slave_d;
         idx_q <= idx_d;
         len_q <= len_d;
         fill_len_q <= fill_len_d;
         rx_q <= rx_d;
         echo_q <= echo_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         prdata_q <= prdata_d;
         stat_req_q <= stat_req_d;
      end
   end

   // ==========================================================
   // addressing hold-off after a slave reports a volatile address
   aid_lock_timer #(
      .CYCLES(LOCK_CYCLES)
   ) u_lock (
      .clk(CLK),
      .rst(RST),
      .start(lock_start),
      .busy(lock_busy)
   );

   // ==========================================================
   // outputs
   assign PRDATA = prdata_q;
   assign PREADY = 1'b1;
   assign PSLVERR = access_ph & ~mapped;
   assign IRQ = |(irq_stat_q & irq_mask_q);
   assign STAT_REQ = stat_req_q;
   assign STAT_SLAVE = slave_q;
   assign STAT_CLEAR = stat_req_q;
   assign ADDR_LOCK = lock_busy;

endmodule : aid_job_ctrl

/* src/aid_lock_timer.sv */
// hold-off timer for addressing calls while a slave stores its address
// assumes start is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module aid_lock_timer #(
   parameter int CYCLES = aid_pkg::LOCK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   output logic busy
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // ==========================================================
   // countdown, retriggered by every new start
   always_comb begin
      cnt_d = cnt_q;
      if (start) begin
         cnt_d = CW'(CYCLES);
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign busy = (cnt_q != '0);

endmodule : aid_lock_timer

/* src/aid_pkg.sv */
// constants shared by the diagnostic job handler and its lock timer
// assumes a single 25 MHz clock and a synchronous active-high reset
package aid_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_HZ = 25000000;
   localparam int LOCK_MS = 15;
   localparam int LOCK_CYC = (CLK_HZ / 1000) * LOCK_MS;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_JOB = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFF_RX_LEN = 8'h10;
   localparam logic [7:0] OFF_RX_BUF = 8'h40;
   localparam int RX_WORDS = 8;
   localparam int RX_BYTES = 32;

   // ==========================================================
   // job codes and answer sizes
   localparam logic [7:0] JOB_ECHO_LIST = 8'h13;
   localparam logic [7:0] JOB_VERSION = 8'h14;
   localparam logic [7:0] JOB_STATUS = 8'h16;
   localparam logic [5:0] ECHO_LEN = 6'h10;
   localparam logic [5:0] VER_LEN = 6'h1E;
   localparam logic [5:0] STAT_LEN = 6'h01;
   localparam logic [4:0] VER_NUM_POS = 5'h1A;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [7:0] CHAR_DOT = 8'h2E;
   localparam int VER_NAME_LEN = 26;
   localparam logic [8*VER_NAME_LEN-1:0] VER_NAME =
      "ASI DIAG MASTER FIRMWARE V";

   // ==========================================================
   // slave status flag positions
   localparam int FLG_ADDR_VOLATILE = 0;
   localparam int FLG_PARITY_ERROR = 1;
   localparam int FLG_END_BIT_ERROR = 2;
   localparam int FLG_NVM_READ_ERROR = 3;

   // ==========================================================
   // status register and interrupt bits
   localparam int STS_BUSY = 0;
   localparam int STS_ADDR_LOCK = 1;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_BAD_JOB = 1;
   localparam int IRQ_VOLATILE = 2;
   localparam int IRQ_BITS = 3;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FILL = 2'b01,
      ST_STAT = 2'b10
   } aid_state_type;

endpackage : aid_pkg
